// ==== hw/tdp_defines.vh ====
`ifndef TDP_DEFINES_VH
`define TDP_DEFINES_VH

// Storage geometry of the large memory block
`define TDP_WORD_W 18
`define TDP_ADDR_W 13
`define TDP_IDX_W 9
`define TDP_DEPTH 512

// Port shapes, depth by width
`define TDP_SHP_8KX1 3'h0
`define TDP_SHP_4KX2 3'h1
`define TDP_SHP_2KX4 3'h2
`define TDP_SHP_1KX8 3'h3
`define TDP_SHP_512X16 3'h4
`define TDP_SHP_1KX9 3'h5
`define TDP_SHP_512X18 3'h6

// Clocking modes
`define TDP_CLK_INDEP 2'h0
`define TDP_CLK_INOUT 2'h1
`define TDP_CLK_RDWR 2'h2
`define TDP_CLK_SINGLE 2'h3

// Memory modes
`define TDP_MEM_TDP 2'h0
`define TDP_MEM_ROM 2'h1
`define TDP_MEM_SHIFT 2'h2
`define TDP_MEM_FIFO 2'h3

// Reset values
`define TDP_RST_Q 18'h00000
`define TDP_RST_PTR 13'h0000

`endif

// ==== hw/tdp_out_stage.v ====
`timescale 1ns/1ps
`include "tdp_defines.vh"

module tdp_out_stage (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Control
  input wire clr,
  input wire loadEn,
  input wire regEn,
  input wire useReg,
  // Data from the array
  input wire [`TDP_WORD_W-1:0] din,
  input wire unkIn,
  // Result
  output reg [`TDP_WORD_W-1:0] q,
  output reg unk
);

  reg [`TDP_WORD_W-1:0] latchData_reg;
  reg latchUnk_reg;

  // Output latch, cleared by rst or clr, loaded by a read, held otherwise
  always @(posedge mclk) begin
    if (rst || clr) begin
      latchData_reg <= `TDP_RST_Q;
      latchUnk_reg <= 1'b0;
    end else if (loadEn) begin
      latchData_reg <= din;
      latchUnk_reg <= unkIn;
    end
  end

  // Visible output: same edge as the latch, or one stage later
  always @(posedge mclk) begin
    if (rst || clr) begin
      q <= `TDP_RST_Q;
      unk <= 1'b0;
    end else if (useReg) begin
      if (regEn) begin
        q <= latchData_reg;
        unk <= latchUnk_reg;
      end
    end else if (loadEn) begin
      q <= din;
      unk <= unkIn;
    end
  end

endmodule // tdp_out_stage

// ==== hw/tdp_ram.v ====
`timescale 1ns/1ps
`include "tdp_defines.vh"

module tdp_ram (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Configuration
  input wire [1:0] memMode,
  input wire [1:0] clkMode,
  input wire rdwNewData,
  input wire outRegA,
  input wire outRegB,
  input wire [2:0] rdShapeA,
  input wire [2:0] wrShapeA,
  input wire [2:0] rdShapeB,
  input wire [2:0] wrShapeB,
  input wire [11:0] tapLen,
  // Port A
  input wire enA,
  input wire [`TDP_ADDR_W-1:0] addrA,
  input wire [`TDP_WORD_W-1:0] dataA,
  input wire wrenA,
  input wire rdenA,
  input wire [1:0] byteEnA,
  input wire clrA,
  // Port B
  input wire enB,
  input wire [`TDP_ADDR_W-1:0] addrB,
  input wire [`TDP_WORD_W-1:0] dataB,
  input wire wrenB,
  input wire rdenB,
  input wire [1:0] byteEnB,
  input wire clrB,
  // Read data and status
  output wire [`TDP_WORD_W-1:0] qA,
  output wire [`TDP_WORD_W-1:0] qB,
  output wire unknownA,
  output wire unknownB,
  output reg collision,
  output reg cfgError
);

  // Word index of an address for a shape
  function [`TDP_IDX_W-1:0] wordIdx;
    input [2:0] s;
    input [`TDP_ADDR_W-1:0] a;
    begin
      case (s)
        `TDP_SHP_8KX1: wordIdx = a[12:4];
        `TDP_SHP_4KX2: wordIdx = a[11:3];
        `TDP_SHP_2KX4: wordIdx = a[10:2];
        `TDP_SHP_1KX8: wordIdx = a[9:1];
        `TDP_SHP_1KX9: wordIdx = a[9:1];
        default: wordIdx = a[8:0];
      endcase
    end
  endfunction

  // Bit offset of the addressed unit inside its word
  function [4:0] bitOff;
    input [2:0] s;
    input [`TDP_ADDR_W-1:0] a;
    begin
      case (s)
        `TDP_SHP_8KX1: bitOff = {1'b0, a[3:0]};
        `TDP_SHP_4KX2: bitOff = {1'b0, a[2:0], 1'b0};
        `TDP_SHP_2KX4: bitOff = {1'b0, a[1:0], 2'h0};
        `TDP_SHP_1KX8: bitOff = {1'b0, a[0], 3'h0};
        `TDP_SHP_1KX9: bitOff = a[0] ? 5'h09 : 5'h00;
        default: bitOff = 5'h00;
      endcase
    end
  endfunction

  // Ones over the data width of a shape
  function [`TDP_WORD_W-1:0] lowMask;
    input [2:0] s;
    begin
      case (s)
        `TDP_SHP_8KX1: lowMask = 18'h00001;
        `TDP_SHP_4KX2: lowMask = 18'h00003;
        `TDP_SHP_2KX4: lowMask = 18'h0000f;
        `TDP_SHP_1KX8: lowMask = 18'h000ff;
        `TDP_SHP_512X16: lowMask = 18'h0ffff;
        `TDP_SHP_1KX9: lowMask = 18'h001ff;
        default: lowMask = 18'h3ffff;
      endcase
    end
  endfunction

  // Parity family flag
  function isParity;
    input [2:0] s;
    begin
      isParity = (s == `TDP_SHP_1KX9) || (s == `TDP_SHP_512X18);
    end
  endfunction

  // Word count of a shape, used to bound the shift length
  function [13:0] unitDepth;
    input [2:0] s;
    begin
      case (s)
        `TDP_SHP_8KX1: unitDepth = 14'h2000;
        `TDP_SHP_4KX2: unitDepth = 14'h1000;
        `TDP_SHP_2KX4: unitDepth = 14'h0800;
        `TDP_SHP_1KX8: unitDepth = 14'h0400;
        `TDP_SHP_1KX9: unitDepth = 14'h0400;
        default: unitDepth = 14'h0200;
      endcase
    end
  endfunction

  // Place write data into storage layout; plain shapes skip parity bits
  function [`TDP_WORD_W-1:0] placeData;
    input [2:0] s;
    input [`TDP_ADDR_W-1:0] a;
    input [`TDP_WORD_W-1:0] d;
    reg [15:0] sh;
    reg [`TDP_WORD_W-1:0] m;
    begin
      m = lowMask(s);
      sh = (d[15:0] & m[15:0]) << bitOff(s, a);
      if (isParity(s))
        placeData = (d & m) << bitOff(s, a);
      else
        placeData = {1'b0, sh[15:8], 1'b0, sh[7:0]};
    end
  endfunction

  // Lane mask from byte enables on full-width shapes
  function [`TDP_WORD_W-1:0] laneMask;
    input [2:0] s;
    input [1:0] be;
    begin
      if (s == `TDP_SHP_512X16 || s == `TDP_SHP_512X18)
        laneMask = {{9{be[1]}}, {9{be[0]}}};
      else
        laneMask = 18'h3ffff;
    end
  endfunction

  // Extract read data from a stored word
  function [`TDP_WORD_W-1:0] pickData;
    input [2:0] s;
    input [`TDP_ADDR_W-1:0] a;
    input [`TDP_WORD_W-1:0] w;
    reg [15:0] pk;
    reg [`TDP_WORD_W-1:0] m;
    begin
      m = lowMask(s);
      pk = {w[16:9], w[7:0]} >> bitOff(s, a);
      if (isParity(s))
        pickData = (w >> bitOff(s, a)) & m;
      else
        pickData = {2'h0, pk & m[15:0]};
    end
  endfunction

  reg [`TDP_WORD_W-1:0] mem [0:`TDP_DEPTH-1];
  reg [`TDP_ADDR_W-1:0] shPtr_reg;
  reg [`TDP_ADDR_W-1:0] shPtr_next;

  reg cfgBad;
  reg inEnA, inEnB, outEnA, outEnB;
  reg wrA, wrB, rdA, rdB;
  reg [2:0] rsA, wsA, rsB, wsB;
  reg [`TDP_ADDR_W-1:0] rdAdA, rdAdB, wrAdA, wrAdB;
  wire [`TDP_ADDR_W-1:0] twoLen = {tapLen, 1'b0};
  wire shiftMode = (memMode == `TDP_MEM_SHIFT);
  wire splitClk = (clkMode == `TDP_CLK_INDEP) ||
                  (clkMode == `TDP_CLK_RDWR);

  // Configuration check
  always @* begin
    cfgBad = 1'b0;
    if (isParity(rsA) != isParity(wsA) || isParity(rsB) != isParity(wsB) ||
        isParity(wsA) != isParity(wsB))
      cfgBad = 1'b1;
    if (rdShapeA > `TDP_SHP_512X18 || wrShapeA > `TDP_SHP_512X18 ||
        rdShapeB > `TDP_SHP_512X18 || wrShapeB > `TDP_SHP_512X18)
      cfgBad = 1'b1;
    case (memMode)
      `TDP_MEM_TDP: cfgBad = cfgBad | (clkMode == `TDP_CLK_RDWR);
      `TDP_MEM_ROM: cfgBad = cfgBad | (clkMode == `TDP_CLK_RDWR);
      `TDP_MEM_FIFO: cfgBad = cfgBad | (clkMode == `TDP_CLK_INDEP) |
                              (clkMode == `TDP_CLK_INOUT);
      default: cfgBad = cfgBad | (clkMode != `TDP_CLK_SINGLE) |
                        (tapLen == 12'h000) |
                        ({1'b0, twoLen} > unitDepth(wrShapeA));
    endcase
  end

  // Register enables for each clocking mode
  always @* begin
    case (clkMode)
      `TDP_CLK_INDEP: begin
        inEnA = enA;
        outEnA = enA;
        inEnB = enB;
        outEnB = enB;
      end
      `TDP_CLK_INOUT: begin
        inEnA = enA;
        inEnB = enA;
        outEnA = enB;
        outEnB = enB;
      end
      `TDP_CLK_RDWR: begin
        inEnA = enA;
        outEnA = enA;
        inEnB = enB;
        outEnB = enB;
      end
      default: begin
        inEnA = enA;
        inEnB = enA;
        outEnA = enA;
        outEnB = enA;
      end
    endcase
  end

  // Strobes, shapes and addresses per memory mode
  always @* begin
    rsA = rdShapeA;
    wsA = wrShapeA;
    rsB = rdShapeB;
    wsB = wrShapeB;
    rdAdA = addrA;
    wrAdA = addrA;
    rdAdB = addrB;
    wrAdB = addrB;
    wrA = inEnA & wrenA;
    rdA = inEnA & rdenA;
    wrB = inEnB & wrenB;
    rdB = inEnB & rdenB;
    case (memMode)
      `TDP_MEM_ROM: begin
        wrA = 1'b0;
        wrB = 1'b0;
      end
      `TDP_MEM_FIFO: begin
        rdA = 1'b0;
        wrB = 1'b0;
      end
      `TDP_MEM_SHIFT: begin
        rsA = wrShapeA;
        rsB = wrShapeA;
        wsB = wrShapeA;
        wrA = inEnA;
        rdA = inEnA;
        rdB = inEnA;
        wrB = 1'b0;
        wrAdA = shPtr_reg;
        rdAdB = shPtr_reg;
        rdAdA = (shPtr_reg < {1'b0, tapLen}) ?
                shPtr_reg + {1'b0, tapLen} :
                shPtr_reg - {1'b0, tapLen};
      end
      default: begin
        rsA = rdShapeA;
      end
    endcase
    if (clkMode == `TDP_CLK_RDWR) begin
      rdA = 1'b0;
      wrB = 1'b0;
    end
    if (cfgBad) begin
      wrA = 1'b0;
      wrB = 1'b0;
      rdA = 1'b0;
      rdB = 1'b0;
    end
  end

  wire [`TDP_IDX_W-1:0] idxWA = wordIdx(wsA, wrAdA);
  wire [`TDP_IDX_W-1:0] idxWB = wordIdx(wsB, wrAdB);
  wire [`TDP_IDX_W-1:0] idxRA = wordIdx(rsA, rdAdA);
  wire [`TDP_IDX_W-1:0] idxRB = wordIdx(rsB, rdAdB);
  wire [`TDP_WORD_W-1:0] mA = placeData(wsA, wrAdA, 18'h3ffff) &
                              laneMask(wsA, byteEnA);
  wire [`TDP_WORD_W-1:0] mB = placeData(wsB, wrAdB, 18'h3ffff) &
                              laneMask(wsB, byteEnB);
  wire [`TDP_WORD_W-1:0] dA = placeData(wsA, wrAdA, dataA);
  wire [`TDP_WORD_W-1:0] dB = placeData(wsB, wrAdB, dataB);
  wire sameWord = wrA & wrB & (idxWA == idxWB);
  wire clash = sameWord & ((mA & mB) != 18'h00000);

  reg [`TDP_WORD_W-1:0] newWA, newWB;

  // Words after merging the writes; an overlap stores scrambled bits
  always @* begin
    newWA = (mem[idxWA] & ~mA) | (dA & mA);
    newWB = (mem[idxWB] & ~mB) | (dB & mB);
    if (sameWord) begin
      newWA = (mem[idxWA] & ~(mA | mB)) | (dA & mA & ~mB) |
              (dB & mB & ~mA) | ((dA ^ dB) & mA & mB);
      newWB = newWA;
    end
  end

  // Array write; contents are never cleared
  always @(posedge mclk) begin
    if (wrA)
      mem[idxWA] <= newWA;
    if (wrB && !sameWord)
      mem[idxWB] <= newWB;
  end

  reg [`TDP_WORD_W-1:0] wordA, wordB;
  reg unkA, unkB;

  // Read path: same-port new or old data, mixed-port old or unknown
  always @* begin
    wordA = mem[idxRA];
    wordB = mem[idxRB];
    unkA = 1'b0;
    unkB = 1'b0;
    if (rdwNewData && !shiftMode && wrA && idxRA == idxWA)
      wordA = newWA;
    if (rdwNewData && !shiftMode && wrB && idxRB == idxWB)
      wordB = newWB;
    if (splitClk && wrB && idxRA == idxWB)
      unkA = 1'b1;
    if (splitClk && wrA && idxRB == idxWA)
      unkB = 1'b1;
  end

  // Shift pointer circulates over twice the tap length
  always @* begin
    shPtr_next = shPtr_reg;
    if (!shiftMode || cfgBad)
      shPtr_next = `TDP_RST_PTR;
    else if (wrA)
      shPtr_next = (shPtr_reg == twoLen - 13'h0001) ?
                   `TDP_RST_PTR : shPtr_reg + 13'h0001;
  end

  // Pointer and status flops
  always @(posedge mclk) begin
    if (rst) begin
      shPtr_reg <= `TDP_RST_PTR;
      collision <= 1'b0;
      cfgError <= 1'b0;
    end else begin
      shPtr_reg <= shPtr_next;
      collision <= clash;
      cfgError <= cfgBad;
    end
  end

  // Output latch and optional output register for each port
  tdp_out_stage stageA (
    .mclk(mclk),
    .rst(rst),
    .clr(clrA),
    .loadEn(rdA),
    .regEn(outEnA),
    .useReg(outRegA),
    .din(pickData(rsA, rdAdA, wordA)),
    .unkIn(unkA),
    .q(qA),
    .unk(unknownA)
  );

  tdp_out_stage stageB (
    .mclk(mclk),
    .rst(rst),
    .clr(clrB),
    .loadEn(rdB),
    .regEn(outEnB),
    .useReg(outRegB),
    .din(pickData(rsB, rdAdB, wordB)),
    .unkIn(unkB),
    .q(qB),
    .unk(unknownB)
  );

endmodule // tdp_ram

// ==== verification/tdp_ram_sva.sv ====
`timescale 1ns/1ps
module tdp_ram_sva (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Configuration
  input wire [1:0] memMode,
  input wire [1:0] clkMode,
  input wire outRegA,
  input wire outRegB,
  input wire [2:0] rdShapeA,
  input wire [2:0] wrShapeA,
  input wire [2:0] rdShapeB,
  input wire [2:0] wrShapeB,
  // Port requests
  input wire enA,
  input wire enB,
  input wire [12:0] addrA,
  input wire [12:0] addrB,
  input wire wrenA,
  input wire rdenA,
  input wire clrA,
  input wire wrenB,
  input wire rdenB,
  input wire clrB,
  // Results
  input wire [17:0] qA,
  input wire unknownB,
  input wire collision,
  input wire cfgError
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // Byte shapes on both ports of the dual-port memory
  wire cfgOk = memMode == 2'h0 && rdShapeA == 3'h3 && wrShapeA == 3'h3
    && rdShapeB == 3'h3 && wrShapeB == 3'h3;
  // Port A has no read, clear, output register or shift traffic
  wire quietA = !outRegA && !rdenA && !clrA && !rst && memMode != 2'h2;

  // Both ports write one word on the shared clock
  sequence dualWr;
    cfgOk && clkMode == 2'h3 && enA && wrenA && wrenB && addrA == addrB;
  endsequence

  // Port B reads the word port A writes, separate enables
  sequence splitRd;
    cfgOk && clkMode == 2'h0 && enA && enB && wrenA && rdenB && !wrenB
      && !clrB && !outRegB && addrA == addrB;
  endsequence

  a_idle_hold: assert property (
    quietA && $past(quietA) |=> $stable(qA))
    else $error("qA changed with no read");
  a_clear_out: assert property (clrA |=> qA == 18'h00000)
    else $error("qA not cleared");
  a_clash_flag: assert property (dualWr |=> collision)
    else $error("dual write gave no collision");
  a_clash_cause: assert property (
    collision |-> $past(wrenA) && $past(wrenB))
    else $error("collision without two writes");
  a_split_unknown: assert property (splitRd |=> unknownB)
    else $error("split read not marked unknown");
  a_family_mix: assert property (
    memMode == 2'h0 && rdShapeA == 3'h5 && wrShapeA == 3'h3 |=> cfgError)
    else $error("mixed families accepted");
  a_clock_mode: assert property (
    memMode == 2'h3 && clkMode == 2'h0 |=> cfgError)
    else $error("bad clock mode accepted");
  a_cfg_clean: assert property (
    cfgOk && clkMode == 2'h3 |=> !cfgError)
    else $error("valid setup flagged");
  a_bad_shape: assert property (rdShapeA == 3'h7 |=> cfgError)
    else $error("shape code 7 accepted");
endmodule // tdp_ram_sva

// ==== verification/tdp_user_drv.sv ====
`timescale 1ns/1ps
`include "tdp_defines.vh"

module tdp_user_drv (
  // Clock
  input wire mclk,
  // Port A requests
  output logic [`TDP_ADDR_W-1:0] addrA,
  output logic [`TDP_WORD_W-1:0] dataA,
  output logic wrenA,
  output logic rdenA,
  // Port B requests
  output logic [`TDP_ADDR_W-1:0] addrB,
  output logic [`TDP_WORD_W-1:0] dataB,
  output logic wrenB,
  output logic rdenB
);
  // Set only by a scenario that breaks the clash guard on purpose
  logic clashOk;

  // Idle requests from time zero
  initial begin
    clashOk = 1'h0;
    {addrA, dataA, wrenA, rdenA} = '0;
    {addrB, dataB, wrenB, rdenB} = '0;
  end

  // One request on both ports, taken at the following edge
  task automatic op(input logic wa, ra, input logic [12:0] aa,
    input logic [17:0] da, input logic wb, rb, input logic [12:0] ab,
    input logic [17:0] db);
    @(posedge mclk);
    addrA <= aa;
    dataA <= da;
    wrenA <= wa;
    rdenA <= ra;
    addrB <= ab;
    dataB <= db;
    // B's write is dropped when port A writes the same address, unless clashOk is set
    wrenB <= wb && !(wa && aa == ab && !clashOk);
    rdenB <= rb;
  endtask

  // Release: strobes drop, data lines carry junk
  task automatic idle;
    @(posedge mclk);
    wrenA <= 1'h0;
    rdenA <= 1'h0;
    wrenB <= 1'h0;
    rdenB <= 1'h0;
    dataA <= ~dataA;
    dataB <= ~dataB;
  endtask
endmodule // tdp_user_drv

// ==== verification/tb_tdp_ram.sv ====
`timescale 1ns/1ps
`include "tdp_defines.vh"

module tb_tdp_ram;
  // Clock, reset and configuration
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] memMode = 2'h0;
  logic [1:0] clkMode = 2'h3;
  logic rdwNewData = 1'h1;
  logic outRegA = 1'h0;
  logic outRegB = 1'h0;
  logic [2:0] rdShapeA = 3'h3;
  logic [2:0] wrShapeA = 3'h3;
  logic [2:0] shapeB = 3'h3;
  logic [1:0] byteEnA = 2'h3;
  logic clrA = 1'h0;
  logic clrB = 1'h0;
  wire [`TDP_ADDR_W-1:0] addrA, addrB;
  wire [`TDP_WORD_W-1:0] dataA, dataB, qA, qB;
  wire wrenA, rdenA, wrenB, rdenB, unknownA, unknownB, collision, cfgError;
  int numErrors = 0;
  int nChecks = 0;

  always #50 mclk = ~mclk;

  tdp_user_drv i_usr (.mclk(mclk), .addrA(addrA), .dataA(dataA),
    .wrenA(wrenA), .rdenA(rdenA), .addrB(addrB), .dataB(dataB),
    .wrenB(wrenB), .rdenB(rdenB));

  tdp_ram i_dut (.mclk(mclk), .rst(rst), .memMode(memMode),
    .clkMode(clkMode), .rdwNewData(rdwNewData), .outRegA(outRegA),
    .outRegB(outRegB), .rdShapeA(rdShapeA), .wrShapeA(wrShapeA),
    .rdShapeB(shapeB), .wrShapeB(shapeB), .tapLen(12'h004), .enA(1'h1),
    .addrA(addrA), .dataA(dataA), .wrenA(wrenA), .rdenA(rdenA),
    .byteEnA(byteEnA), .clrA(clrA), .enB(1'h1), .addrB(addrB),
    .dataB(dataB), .wrenB(wrenB), .rdenB(rdenB), .byteEnB(2'h3),
    .clrB(clrB), .qA(qA), .qB(qB), .unknownA(unknownA),
    .unknownB(unknownB), .collision(collision), .cfgError(cfgError));

  // Compare and count
  task automatic chk(input logic [17:0] got, exp, input string what);
    nChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("FAIL at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Two writes, two reads, then one of each, crossing ports
  task t_cross;
    i_usr.op(1'h1, 1'h0, 13'h5, 18'h5a, 1'h1, 1'h0, 13'h3ff, 18'hc3);
    i_usr.op(1'h0, 1'h1, 13'h3ff, 18'h0, 1'h0, 1'h1, 13'h5, 18'h0);
    i_usr.idle();
    #1 chk(qA, 18'h0c3, "read A");
    chk(qB, 18'h05a, "read B");
    i_usr.op(1'h1, 1'h0, 13'h9, 18'h11, 1'h0, 1'h1, 13'h3ff, 18'h0);
    i_usr.idle();
    #1 chk(qB, 18'h0c3, "read with write");
    $display("t_cross done");
  endtask

  // Output registers add exactly one cycle
  task t_oreg;
    @(posedge mclk);
    outRegA <= 1'h1;
    outRegB <= 1'h1;
    i_usr.op(1'h0, 1'h1, 13'h5, 18'h0, 1'h0, 1'h1, 13'h9, 18'h0);
    i_usr.idle();
    #1 chk(qA, 18'h0c3, "early A");
    chk(qB, 18'h0c3, "early B");
    @(posedge mclk);
    #1 chk(qA, 18'h05a, "late A");
    chk(qB, 18'h011, "late B");
    @(posedge mclk);
    outRegA <= 1'h0;
    outRegB <= 1'h0;
    $display("t_oreg done");
  endtask

  // Same-port read during write, new then old data
  task t_rdw;
    logic [17:0] prev;
    prev = 18'h05a;
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      rdwNewData <= (i == 0);
      i_usr.op(1'h1, 1'h1, 13'h5, 18'h66 + 18'(i), 1'h0, 1'h0, 13'h0, 18'h0);
      i_usr.idle();
      #1 chk(qA, i == 0 ? 18'h066 : prev, "same port");
      prev = 18'h66 + 18'(i);
    end
    $display("t_rdw done");
  endtask

  // Mixed-port read during write, separate then shared enables
  task t_mix;
    logic [17:0] prev;
    prev = 18'h011;
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk);
      clkMode <= i == 0 ? 2'h0 : 2'h3;
      i_usr.op(1'h1, 1'h0, 13'h9, 18'h33 + 18'(i), 1'h0, 1'h1, 13'h9, 18'h0);
      i_usr.idle();
      #1 chk(qB, prev, "mixed old data");
      chk({17'h0, unknownB}, {17'h0, i == 0}, "unknown flag");
      prev = 18'h33 + 18'(i);
    end
    // Port B writes while port A reads, separate enables
    @(posedge mclk);
    clkMode <= 2'h0;
    i_usr.op(1'h0, 1'h1, 13'h9, 18'h0, 1'h1, 1'h0, 13'h9, 18'h35);
    i_usr.idle();
    #1 chk(qA, 18'h034, "A old data");
    chk({17'h0, unknownA}, 18'h1, "unknown A");
    clkMode <= 2'h3;
    $display("t_mix done");
  endtask

  // Clashing writes, then the same with the guard in place
  task t_clash;
    for (int i = 0; i < 2; i++) begin
      i_usr.clashOk = (i == 0);
      i_usr.op(1'h1, 1'h0, 13'h20, 18'h0f, 1'h1, 1'h0, 13'h20, 18'hf0);
      i_usr.idle();
      #1 chk({17'h0, collision}, {17'h0, i == 0}, "collision");
      i_usr.op(1'h0, 1'h1, 13'h20, 18'h0, 1'h0, 1'h0, 13'h0, 18'h0);
      i_usr.idle();
      #1 chk(qA, i == 0 ? 18'h0ff : 18'h00f, "clash word");
    end
    i_usr.clashOk = 1'h0;
    $display("t_clash done");
  endtask

  // Clear empties outputs but leaves contents
  task t_clr;
    @(posedge mclk);
    clrA <= 1'h1;
    clrB <= 1'h1;
    @(posedge mclk);
    clrA <= 1'h0;
    clrB <= 1'h0;
    #1 chk(qA | qB, 18'h0, "cleared");
    i_usr.op(1'h0, 1'h1, 13'h20, 18'h0, 1'h0, 1'h0, 13'h0, 18'h0);
    i_usr.idle();
    #1 chk(qA, 18'h00f, "kept");
    $display("t_clr done");
  endtask

  // Bad shape, mixed family, bad clock mode: flagged, writes blocked
  task t_cfg;
    logic [2:0] shp [3] = '{3'h7, 3'h5, 3'h3};
    logic [1:0] mm [3] = '{2'h0, 2'h0, 2'h3};
    logic [1:0] cm [3] = '{2'h3, 2'h3, 2'h0};
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      rdShapeA <= shp[i];
      memMode <= mm[i];
      clkMode <= cm[i];
      i_usr.op(1'h1, 1'h0, 13'h5, 18'h3c, 1'h0, 1'h0, 13'h0, 18'h0);
      i_usr.idle();
      #1 chk({17'h0, cfgError}, 18'h1, "config error");
      @(posedge mclk);
      rdShapeA <= 3'h3;
      memMode <= 2'h0;
      clkMode <= 2'h3;
    end
    i_usr.op(1'h0, 1'h1, 13'h5, 18'h0, 1'h0, 1'h0, 13'h0, 18'h0);
    i_usr.idle();
    #1 chk(qA, 18'h067, "blocked write");
    $display("t_cfg done");
  endtask

  // Read-only mode ignores writes
  task t_rom;
    @(posedge mclk);
    memMode <= 2'h1;
    i_usr.op(1'h1, 1'h0, 13'h5, 18'h99, 1'h0, 1'h0, 13'h0, 18'h0);
    i_usr.op(1'h0, 1'h1, 13'h5, 18'h0, 1'h0, 1'h0, 13'h0, 18'h0);
    i_usr.idle();
    #1 chk(qA, 18'h067, "rom read");
    memMode <= 2'h0;
    $display("t_rom done");
  endtask

  // Shift mode, taps of 4 words: A shows m edges back, B 2m back
  task t_shift;
    @(posedge mclk);
    memMode <= 2'h2;
    for (int i = 0; i < 10; i++) begin
      i_usr.op(1'h1, 1'h0, 13'h0, 18'h80 + 18'(i), 1'h0, 1'h0, 13'h0, 18'h0);
    end
    i_usr.idle();
    #1 chk(qA, 18'h085, "tap m");
    chk(qB, 18'h081, "tap 2m");
    memMode <= 2'h0;
    $display("t_shift done");
  endtask

  // Byte lanes masked on a 16-bit shape
  task t_be;
    @(posedge mclk);
    rdShapeA <= 3'h4;
    wrShapeA <= 3'h4;
    shapeB <= 3'h4;
    i_usr.op(1'h1, 1'h0, 13'h1, 18'hffff, 1'h0, 1'h0, 13'h0, 18'h0);
    i_usr.idle();
    byteEnA <= 2'h1;
    i_usr.op(1'h1, 1'h0, 13'h1, 18'h0, 1'h0, 1'h0, 13'h0, 18'h0);
    i_usr.idle();
    byteEnA <= 2'h3;
    i_usr.op(1'h0, 1'h1, 13'h1, 18'h0, 1'h0, 1'h0, 13'h0, 18'h0);
    i_usr.idle();
    #1 chk(qA, 18'h0ff00, "byte lanes");
    $display("t_be done");
  endtask

  // Verdict
  task tally_and_finish;
    $display("checks %0d errors %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 80 cycles of the run
  initial begin
    repeat (3000) @(posedge mclk);
    numErrors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    t_cross();
    t_oreg();
    t_rdw();
    t_mix();
    t_clash();
    t_clr();
    t_cfg();
    t_rom();
    t_shift();
    t_be();
    tally_and_finish();
  end
endmodule // tb_tdp_ram

bind tdp_ram tdp_ram_sva i_sva (.mclk(mclk), .rst(rst), .memMode(memMode),
  .clkMode(clkMode), .outRegA(outRegA), .outRegB(outRegB),
  .rdShapeA(rdShapeA), .wrShapeA(wrShapeA), .rdShapeB(rdShapeB),
  .wrShapeB(wrShapeB), .enA(enA), .enB(enB), .addrA(addrA),
  .addrB(addrB), .wrenA(wrenA), .rdenA(rdenA), .clrA(clrA),
  .wrenB(wrenB), .rdenB(rdenB), .clrB(clrB), .qA(qA),
  .unknownB(unknownB), .collision(collision), .cfgError(cfgError));
